// ==== pio_pkg.sv ====
package pio_pkg;
  localparam int PORT_COUNT = 10;
  localparam int PORT_W     = 16;
  localparam int DRV_W      = 16;
  localparam int BUSDRV_W   = 8;
  localparam logic [3:0] PORT_IDX_P0_LO = 4'h0;
  localparam logic [3:0] PORT_IDX_P0_HI = 4'h1;
  localparam logic [3:0] PORT_IDX_P1_LO = 4'h2;
  localparam logic [3:0] PORT_IDX_P1_HI = 4'h3;
  localparam logic [3:0] PORT_IDX_P2  = 4'h4;
  localparam logic [3:0] PORT_IDX_P3  = 4'h5;
  localparam logic [3:0] PORT_IDX_P4  = 4'h6;
  localparam logic [3:0] PORT_IDX_P5  = 4'h7;
  localparam logic [3:0] PORT_IDX_P6  = 4'h8;
  localparam logic [3:0] PORT_IDX_P7  = 4'h9;
  localparam logic [15:0] WIDTH_MASK [PORT_COUNT] = '{
    16'h00ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'hffff,
    16'hbfff, 16'h00ff, 16'hffff, 16'h00ff, 16'h00ff};
  localparam logic [PORT_COUNT-1:0] HAS_DRAIN_SEL = 10'b1101110000;
  localparam logic [PORT_COUNT-1:0] HAS_LEVEL_SEL = 10'b1001110000;
  localparam logic [PORT_COUNT-1:0] HAS_OUTPUT    = 10'b1101111111;
  localparam logic [15:0] DIR_RESET   = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  typedef enum logic [1:0] {PIO_OP_NONE, PIO_OP_WRITE, PIO_OP_RMW} pio_op_t;
  typedef enum logic [2:0] {
    PIO_RMW_AND, PIO_RMW_OR, PIO_RMW_XOR, PIO_RMW_SET_BIT, PIO_RMW_CLR_BIT
  } pio_rmw_t;
endpackage

// ==== pio_port_if.sv ====
`timescale 1ns/100ps
interface pio_port_if;
  import pio_pkg::*;
  logic [3:0]  sel;
  logic        we;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output sel, output we, output wdata, input rdata);
  modport mem (input sel, input we, input wdata, output rdata);
endinterface

// ==== pio_latch_mem.sv ====
`timescale 1ns/100ps
module pio_latch_mem
  import pio_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  pio_port_if.mem   lp,
  output logic [PORT_COUNT*PORT_W-1:0] latch_flat
);
  logic [15:0] latch_q [PORT_COUNT];
  logic [15:0] rdata_q;

  always_ff @(posedge mclk) begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (rst) begin
        latch_q[i] <= LATCH_RESET;
      end else if (lp.we && lp.sel == 4'(i) && HAS_OUTPUT[i]) begin
        latch_q[i] <= lp.wdata & WIDTH_MASK[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (lp.sel < 4'(PORT_COUNT)) begin
      rdata_q <= latch_q[lp.sel];
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign lp.rdata = rdata_q;

  always_comb begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      latch_flat[i*PORT_W +: PORT_W] = latch_q[i];
    end
  end
endmodule

// ==== pio_bank.sv ====
// How it works
// - Every pin level is sampled into the input latch each clock.
// - Writing an input pin stores the latch value but keeps it undriven.
// - Reading an input pin returns its sampled pin level.
// - Modify on an input pin uses pin level, result goes to latch.
// - Direction bit 1 enables driver; writes reach latch and pin.
// - Reading an output pin returns the output latch contents.
// - Modify on an output pin uses latch, writes latch, so pin follows.
// - Ports 2,3,4,6,7 have per-bit push-pull or open-drain selection.
// - Ports 2,3,4,7 have a software TTL or CMOS threshold select.
// - Ports 0-4,6,7 have drive strength and edge-rate controls.
// - A separate register sets drive of latch, read and write strobes.
// - Widths: P0,P1 as byte halves, P2 and P5 16, P3 15 minus bit 14, others 8.
// - Port 5 is 16-bit input only, with no latch or driver.
`timescale 1ns/100ps
module pio_bank
  import pio_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic [3:0]                    acc_port,
  input  wire pio_op_t                       acc_op,
  input  wire pio_rmw_t                      acc_rmw,
  input  wire logic [15:0]                   acc_wdata,
  input  wire logic                          acc_rd,
  output logic [15:0]                        acc_rdata,
  output logic                               acc_rvalid,
  input  wire logic [15:0]                   dir_wdata,
  input  wire logic                          dir_we,
  input  wire logic [15:0]                   drain_wdata,
  input  wire logic                          drain_we,
  input  wire logic [15:0]                   drive_wdata,
  input  wire logic                          drive_we,
  input  wire logic [4:0]                    level_wdata,
  input  wire logic                          level_we,
  input  wire logic [BUSDRV_W-1:0]           busdrv_wdata,
  input  wire logic                          busdrv_we,
  input  wire logic [PORT_COUNT*PORT_W-1:0]  pin_in,
  output logic [PORT_COUNT*PORT_W-1:0]       pin_out,
  output logic [PORT_COUNT*PORT_W-1:0]       pin_oe_n,
  output logic [PORT_COUNT*DRV_W-1:0]        output_drive_ctl_reg,
  output logic [4:0]                         input_level_select_reg,
  output logic [BUSDRV_W-1:0]                bus_line_drive_ctl_reg
);
  logic [15:0] pin_direction_reg_q [PORT_COUNT];
  logic [15:0] drain_mode_reg_q    [PORT_COUNT];
  logic [15:0] drive_ctl_q         [PORT_COUNT];
  logic [15:0] sample_q            [PORT_COUNT];
  logic [4:0]  level_q;
  logic [BUSDRV_W-1:0] busdrv_q;
  logic [PORT_COUNT*PORT_W-1:0] latch_flat;
  logic [15:0] operand_d;
  logic [15:0] result_d;
  logic        rmw_pend_q;
  logic [3:0]  rmw_port_q;
  pio_rmw_t    rmw_kind_q;
  logic [15:0] rmw_arg_q;
  logic        rd_pend_q;
  logic [3:0]  rd_port_q;
  logic [PORT_COUNT*PORT_W-1:0] pin_out_q;
  logic [PORT_COUNT*PORT_W-1:0] pin_oe_n_q;
  logic [15:0] acc_rdata_q;
  logic        acc_rvalid_q;

  pio_port_if lp ();

  pio_latch_mem u_mem (
    .mclk       (mclk),
    .rst        (rst),
    .lp         (lp),
    .latch_flat (latch_flat)
  );

  // Per-bit pick between latch and pin; this one mux serves reads and RMW.
  function automatic logic [15:0] view_of(input logic [3:0] p);
    logic [15:0] dir;
    logic [15:0] lat;
    dir = '0;
    lat = '0;
    if (p < 4'(PORT_COUNT)) begin
      dir = pin_direction_reg_q[p];
      lat = latch_flat[p*PORT_W +: PORT_W];
      return ((dir & lat) | (~dir & sample_q[p])) & WIDTH_MASK[p];
    end
    return 16'h0000;
  endfunction

  function automatic logic [15:0] apply_rmw(input pio_rmw_t k,
                                            input logic [15:0] a,
                                            input logic [15:0] b);
    case (k)
      PIO_RMW_AND:     return a & b;
      PIO_RMW_OR:      return a | b;
      PIO_RMW_XOR:     return a ^ b;
      PIO_RMW_SET_BIT: return a | (16'h0001 << b[3:0]);
      PIO_RMW_CLR_BIT: return a & ~(16'h0001 << b[3:0]);
      default:         return a;
    endcase
  endfunction

  always_ff @(posedge mclk) begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      sample_q[i] <= pin_in[i*PORT_W +: PORT_W] & WIDTH_MASK[i];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (rst) begin
        pin_direction_reg_q[i] <= DIR_RESET;
        drain_mode_reg_q[i]    <= CFG_RESET;
        drive_ctl_q[i]         <= CFG_RESET;
      end else if (acc_port == 4'(i)) begin
        if (dir_we && HAS_OUTPUT[i]) begin
          pin_direction_reg_q[i] <= dir_wdata & WIDTH_MASK[i];
        end
        if (drain_we && HAS_DRAIN_SEL[i]) begin
          drain_mode_reg_q[i] <= drain_wdata & WIDTH_MASK[i];
        end
        if (drive_we && HAS_OUTPUT[i]) begin
          drive_ctl_q[i] <= drive_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      level_q  <= 5'h00;
      busdrv_q <= 8'h00;
    end else begin
      if (level_we) begin
        level_q <= level_wdata;
      end
      if (busdrv_we) begin
        busdrv_q <= busdrv_wdata;
      end
    end
  end

  // RMW registers its request when issued; the next cycle reads the operand and writes.
  always_comb begin
    operand_d = view_of(rmw_port_q);
    // The view is the operand; the argument is the mask or the bit number.
    result_d  = apply_rmw(rmw_kind_q, operand_d, rmw_arg_q);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rmw_pend_q <= 1'b0;
      rmw_port_q <= 4'h0;
      rmw_kind_q <= PIO_RMW_AND;
      rmw_arg_q  <= 16'h0000;
    end else begin
      rmw_pend_q <= (acc_op == PIO_OP_RMW);
      rmw_port_q <= acc_port;
      rmw_kind_q <= acc_rmw;
      rmw_arg_q  <= acc_wdata;
    end
  end

  always_comb begin
    lp.sel   = rmw_pend_q ? rmw_port_q : acc_port;
    lp.we    = rmw_pend_q || (acc_op == PIO_OP_WRITE);
    lp.wdata = rmw_pend_q ? result_d : acc_wdata;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_pend_q    <= 1'b0;
      rd_port_q    <= 4'h0;
      acc_rdata_q  <= 16'h0000;
      acc_rvalid_q <= 1'b0;
    end else begin
      rd_pend_q    <= acc_rd;
      rd_port_q    <= acc_port;
      acc_rvalid_q <= rd_pend_q;
      if (rd_pend_q) begin
        acc_rdata_q <= view_of(rd_port_q);
      end
    end
  end

  // Open-drain pins drive only a low; a high releases the pin.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      for (int b = 0; b < PORT_W; b++) begin
        if (rst) begin
          pin_out_q[i*PORT_W+b]  <= 1'b0;
          pin_oe_n_q[i*PORT_W+b] <= 1'b1;
        end else begin
          pin_out_q[i*PORT_W+b] <= latch_flat[i*PORT_W+b];
          pin_oe_n_q[i*PORT_W+b] <= ~(pin_direction_reg_q[i][b]
            & ~(drain_mode_reg_q[i][b] & latch_flat[i*PORT_W+b]));
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PORT_COUNT; i++) begin
      output_drive_ctl_reg[i*DRV_W +: DRV_W] = drive_ctl_q[i];
    end
  end

  assign pin_out                = pin_out_q;
  assign pin_oe_n               = pin_oe_n_q;
  assign acc_rdata              = acc_rdata_q;
  assign acc_rvalid             = acc_rvalid_q;
  assign input_level_select_reg = level_q;
  assign bus_line_drive_ctl_reg = busdrv_q;

  a_reset_inputs: assert property (@(posedge mclk)
    $past(rst) |-> pin_oe_n == '1)
    else $error("pins driven right after reset");
  a_input_no_drive: assert property (@(posedge mclk) disable iff (rst)
    pin_direction_reg_q[4][0] == 1'b0 |=> pin_oe_n[4*PORT_W] == 1'b1)
    else $error("input pin driven");
  a_port5_never: assert property (@(posedge mclk) disable iff (rst)
    pin_oe_n[7*PORT_W +: PORT_W] == 16'hffff)
    else $error("port 5 driven");
  a_p3_bit14_low: assert property (@(posedge mclk) disable iff (rst)
    pin_oe_n[5*PORT_W+14] == 1'b1)
    else $error("port 3 bit 14 driven");
  a_sample_pin: assert property (@(posedge mclk) disable iff (rst)
    sample_q[4] == $past(pin_in[4*PORT_W +: PORT_W]))
    else $error("sample lost");
  sequence s_read_issue;
    acc_rd && !rst;
  endsequence
  a_read_latency: assert property (@(posedge mclk) disable iff (rst)
    s_read_issue |-> ##2 acc_rvalid)
    else $error("read answer late");
  a_write_output: assert property (@(posedge mclk) disable iff (rst)
    (acc_op == PIO_OP_WRITE && acc_port == PORT_IDX_P2 && !rmw_pend_q
     && pin_direction_reg_q[4] == 16'hffff && !dir_we)
    |-> ##2 pin_out[4*PORT_W +: PORT_W] == $past(acc_wdata, 2))
    else $error("output pin not updated");
  a_level_hold: assert property (@(posedge mclk) disable iff (rst)
    !level_we |=> $stable(input_level_select_reg))
    else $error("threshold changed");
  a_busdrv_hold: assert property (@(posedge mclk) disable iff (rst)
    !busdrv_we |=> $stable(bus_line_drive_ctl_reg))
    else $error("strobe drive changed");
  a_drain_p0: assert property (@(posedge mclk) disable iff (rst)
    drain_mode_reg_q[0] == 16'h0000)
    else $error("port 0 drain set");
  a_rmw_operand: assert property (@(posedge mclk) disable iff (rst)
    rmw_pend_q && rmw_port_q == PORT_IDX_P2
    |-> lp.rdata == latch_flat[4*PORT_W +: PORT_W])
    else $error("modify operand stale");
endmodule

// ==== pio_pins_model.sv ====
`timescale 1ns/100ps
module pio_pins_model
  import pio_pkg::*;
(
  input  wire logic [PORT_COUNT*PORT_W-1:0] pin_out,
  input  wire logic [PORT_COUNT*PORT_W-1:0] pin_oe_n,
  input  wire logic [PORT_COUNT*PORT_W-1:0] board_val,
  output logic [PORT_COUNT*PORT_W-1:0]      pin_in
);
  // A released pin shows the board level, never the last driven value.
  always_comb begin
    for (int i = 0; i < PORT_COUNT*PORT_W; i++) begin
      pin_in[i] = pin_oe_n[i] ? board_val[i] : pin_out[i];
    end
  end
endmodule

// ==== pio_bank_tb.sv ====
`timescale 1ns/100ps
module pio_bank_tb;
  import pio_pkg::*;
  localparam int N = PORT_COUNT*PORT_W;
  logic           mclk;
  logic           rst;
  logic [3:0]     acc_port;
  pio_op_t        acc_op;
  pio_rmw_t       acc_rmw;
  logic [15:0]    acc_wdata;
  logic           acc_rd;
  logic [15:0]    acc_rdata;
  logic           acc_rvalid;
  logic [15:0]    cfg_d;
  logic [4:0]     we;
  logic [N-1:0]   pin_in;
  logic [N-1:0]   pin_out;
  logic [N-1:0]   pin_oe_n;
  logic [N-1:0]   board;
  logic [N-1:0]   drv_ctl;
  logic [4:0]     lvl_sel;
  logic [7:0]     bus_drv;
  int             errors;
  int             cmp_count;

  pio_bank i_pio_bank (
    .mclk, .rst, .acc_port, .acc_op, .acc_rmw, .acc_wdata, .acc_rd,
    .acc_rdata, .acc_rvalid, .dir_wdata(cfg_d), .dir_we(we[0]),
    .drain_wdata(cfg_d), .drain_we(we[1]), .drive_wdata(cfg_d),
    .drive_we(we[2]), .level_wdata(cfg_d[4:0]), .level_we(we[3]),
    .busdrv_wdata(cfg_d[7:0]), .busdrv_we(we[4]), .pin_in, .pin_out,
    .pin_oe_n, .output_drive_ctl_reg(drv_ctl),
    .input_level_select_reg(lvl_sel), .bus_line_drive_ctl_reg(bus_drv)
  );
  pio_pins_model i_pio_pins_model (
    .pin_out, .pin_oe_n, .board_val(board), .pin_in
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Enable k: 0 direction, 1 drain, 2 drive, 3 threshold, 4 strobe drive.
  task automatic cfg(input int k, input logic [3:0] p, input logic [15:0] d);
    @(posedge mclk);
    acc_port <= p;
    cfg_d <= d;
    we[k] <= 1'b1;
    @(posedge mclk);
    we <= 5'h00;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // The idle edges afterwards also give a modify the spacing it needs.
  task automatic acc(input logic [3:0] p, input pio_op_t o,
                     input logic [15:0] d, input pio_rmw_t r = PIO_RMW_AND);
    @(posedge mclk);
    acc_port <= p;
    acc_op <= o;
    acc_rmw <= r;
    acc_wdata <= d;
    @(posedge mclk);
    acc_op <= PIO_OP_NONE;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [3:0] p, input logic [15:0] exp);
    int i;
    @(posedge mclk);
    acc_port <= p;
    acc_rd <= 1'b1;
    @(posedge mclk);
    acc_rd <= 1'b0;
    #1;
    for (i = 0; i < 8 && acc_rvalid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 8) begin
      errors++;
      print_verdict();
    end else begin
      chk(acc_rdata, exp);
    end
  endtask

  task automatic t_io();
    board[64+:16] = 16'h5a5a;
    acc(4'h4, PIO_OP_WRITE, 16'h1234);
    chk(pin_oe_n[64+:16], 16'hffff);
    rd(4'h4, 16'h5a5a);
    board[64+:16] = 16'h00f0;
    repeat (2) @(posedge mclk);
    rd(4'h4, 16'h00f0);
    acc(4'h4, PIO_OP_RMW, 16'h000f, PIO_RMW_OR);
    cfg(0, 4'h4, 16'hffff);
    chk(pin_out[64+:16], 16'h00ff);
    chk(pin_oe_n[64+:16], 16'h0000);
    acc(4'h4, PIO_OP_WRITE, 16'h3c3c);
    chk(pin_out[64+:16], 16'h3c3c);
    $display("test io done");
  endtask

  task automatic t_drain();
    cfg(1, 4'h4, 16'hffff);
    board[64+:16] = 16'h0000;
    acc(4'h4, PIO_OP_WRITE, 16'h00ff);
    chk(pin_oe_n[64+:16], 16'h00ff);
    rd(4'h4, 16'h00ff);
    acc(4'h4, PIO_OP_RMW, 16'h0f0f, PIO_RMW_XOR);
    rd(4'h4, 16'h0ff0);
    chk(pin_oe_n[64+:16], 16'h0ff0);
    acc(4'h4, PIO_OP_RMW, 16'h00f0, PIO_RMW_AND);
    rd(4'h4, 16'h00f0);
    acc(4'h4, PIO_OP_RMW, 16'h0003, PIO_RMW_SET_BIT);
    rd(4'h4, 16'h00f8);
    acc(4'h4, PIO_OP_RMW, 16'h0004, PIO_RMW_CLR_BIT);
    rd(4'h4, 16'h00e8);
    cfg(0, 4'h0, 16'h00ff);
    cfg(1, 4'h0, 16'h00ff);
    acc(4'h0, PIO_OP_WRITE, 16'h00ff);
    chk({8'h00, pin_oe_n[7:0]}, 16'h0000);
    $display("test drain done");
  endtask

  task automatic t_width();
    cfg(0, 4'h5, 16'hffff);
    acc(4'h5, PIO_OP_WRITE, 16'hffff);
    chk(pin_oe_n[80+:16], 16'h4000);
    board[112+:16] = 16'hc35a;
    cfg(0, 4'h7, 16'hffff);
    acc(4'h7, PIO_OP_WRITE, 16'hffff);
    chk(pin_oe_n[112+:16], 16'hffff);
    rd(4'h7, 16'hc35a);
    $display("test width done");
  endtask

  task automatic t_cfg();
    cfg(2, 4'h4, 16'h5aa5);
    chk(drv_ctl[64+:16], 16'h5aa5);
    cfg(3, 4'h0, 16'h0015);
    chk({11'h000, lvl_sel}, 16'h0015);
    cfg(4, 4'h0, 16'h00a5);
    chk({8'h00, bus_drv}, 16'h00a5);
    $display("test cfg done");
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    acc_port = 4'h0;
    acc_op = PIO_OP_NONE;
    acc_rmw = PIO_RMW_AND;
    acc_wdata = 16'h0000;
    acc_rd = 1'b0;
    cfg_d = 16'h0000;
    we = 5'h00;
    board = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({15'h0000, &pin_oe_n}, 16'h0001);
    $display("test reset done");
    t_io();
    t_drain();
    t_width();
    t_cfg();
    print_verdict();
  end
endmodule
